//--- rtl/lmt_trip.v
// Latching limit trip logic with APB registers and interrupt
`timescale 1ns/100ps
`include "lmt_consts.vh"

// Behaviour
// - A limit violation lights the exceeded lamp, sets the trip latch and drops the relay.
// - Back in range, the exceeded lamp goes out but the trip latch stays set.
// - After start-up, only an operator acknowledgement clears the trip latch and its lamp.
// - The acknowledgement comes from the front key or the external contact, per a setup bit.
// - An acknowledgement during a violation is ignored and the latch stays set.
// - Latch set means relay off (NC closed, NO open); latch clear means relay on.
// - Restart mode 0 sets the latch at power-on whatever the measured value.
// - In restart mode 0 an in-range acknowledgement energizes the relay and clears the lamp.
// - Restart mode 1 starts with the relay on and lamp off unless the value violates.
// - Level lamps: easy lights easy only, standard none, expert lights expert only.
// - The event lamp shows alarms 1 to 3, with further sources selectable.
// - A configured password lights the security lamp and locks the control, setpoint and range settings.
// - The value display turns red on abnormality and shows an error code on error.
// - The measured value is scaled so range low is 0 % and range high is 100 %.
module lmt_trip (
	// APB slave
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Measurement, same clock
	input  wire [15:0] measured_value,
	input  wire        measured_error,
	// Pins from outside
	input  wire        ack_key_n,
	input  wire        ack_contact,
	input  wire [2:0]  alarm_in,
	input  wire        restart_power_on_mode,
	// Lamps and display
	output reg         exceeded_lamp,
	output reg         trip_lamp,
	output reg         easy_level_lamp,
	output reg         expert_level_lamp,
	output reg         event_lamp,
	output reg         security_lamp,
	output reg         value_red,
	output reg         value_error_code,
	// Relay
	output reg         relay_energized,
	output reg         relay_nc_closed,
	output reg         relay_no_closed,
	// Interrupt
	output reg         irq
);

	// ************************
	// Declarations
	// ************************
	reg  [3:0]  ctrl_reg;
	reg  [15:0] limit_setpoint_reg;
	reg  [15:0] range_lo_reg;
	reg  [15:0] range_hi_reg;
	reg  [15:0] password_reg;
	reg         locked_reg;
	reg  [4:0]  evsel_reg;
	reg  [3:0]  irq_sts_reg;
	reg  [3:0]  irq_mask_reg;
	reg  [5:0]  sync1_reg;
	reg  [5:0]  sync2_reg;
	reg         ack_prev_reg;
	reg  [1:0]  start_cnt_reg;
	reg         started_reg;
	reg         trip_reg;
	reg         trip_next;
	reg  [6:0]  pct_reg;
	reg         abnormal_reg;
	reg  [3:0]  irq_sts_next;
	reg  [31:0] rd_next;
	reg         map_hit;

	wire        setup_ph;
	wire        wr_en;
	wire        lock_ok;
	wire        high_mode;
	wire        violate;
	wire        ack_lvl;
	wire        ack_pulse;
	wire        ack_ok;
	wire        ack_bad;
	wire [3:0]  irq_ev;
	wire [3:0]  irq_clr;
	wire [16:0] off_val;
	wire [16:0] span_val;
	wire        below_lo;
	wire        above_hi;
	wire        in_range;
	wire        div_busy;
	wire        div_done;
	wire [23:0] div_quo;
	wire [23:0] div_num;
	wire [1:0]  lvl;
	wire        alarm_any;

	// ************************
	// Bus decode
	// ************************
	assign setup_ph = psel & ~penable;
	assign wr_en    = psel & penable & pready & pwrite;
	assign lock_ok  = wr_en & ~locked_reg;

	always @* begin
		map_hit = 1'b1;
		rd_next = 32'h00000000;
		case (paddr)
		`LMT_OFS_CTRL:     rd_next[3:0]  = ctrl_reg;
		`LMT_OFS_SETPOINT: rd_next[15:0] = limit_setpoint_reg;
		`LMT_OFS_RANGE_LO: rd_next[15:0] = range_lo_reg;
		`LMT_OFS_RANGE_HI: rd_next[15:0] = range_hi_reg;
		// The stored password itself is never readable
		`LMT_OFS_PASSWORD: rd_next[0]    = locked_reg;
		`LMT_OFS_STATUS: begin
			rd_next[`LMT_ST_EXCEED]   = exceeded_lamp;
			rd_next[`LMT_ST_TRIP]     = trip_reg;
			rd_next[`LMT_ST_RELAY]    = relay_energized;
			rd_next[`LMT_ST_LOCKED]   = locked_reg;
			rd_next[`LMT_ST_ABNORMAL] = abnormal_reg;
			rd_next[`LMT_ST_ERROR]    = measured_error;
			rd_next[`LMT_ST_STARTED]  = started_reg;
		end
		`LMT_OFS_PERCENT:  rd_next[6:0]  = pct_reg;
		`LMT_OFS_EVSEL:    rd_next[4:0]  = evsel_reg;
		`LMT_OFS_IRQ_STS:  rd_next[3:0]  = irq_sts_reg;
		`LMT_OFS_IRQ_MASK: rd_next[3:0]  = irq_mask_reg;
		default:           map_hit       = 1'b0;
		endcase
	end

	// Zero wait states: answer is prepared in the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~map_hit;
			if (setup_ph) begin
				prdata <= pwrite ? 32'h00000000 : rd_next;
			end
		end
	end

	// ************************
	// Setup registers
	// ************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg           <= `LMT_CTRL_RST;
			limit_setpoint_reg <= `LMT_SETPT_RST;
			range_lo_reg       <= `LMT_LO_RST;
			range_hi_reg       <= `LMT_HI_RST;
			password_reg       <= 16'h0000;
			locked_reg         <= 1'b0;
			evsel_reg          <= `LMT_EVSEL_RST;
			irq_mask_reg       <= 4'h0;
		end else begin
			if (lock_ok && paddr == `LMT_OFS_CTRL) begin
				ctrl_reg <= pwdata[3:0];
			end
			if (lock_ok && paddr == `LMT_OFS_SETPOINT) begin
				limit_setpoint_reg <= pwdata[15:0];
			end
			if (lock_ok && paddr == `LMT_OFS_RANGE_LO) begin
				range_lo_reg <= pwdata[15:0];
			end
			if (lock_ok && paddr == `LMT_OFS_RANGE_HI) begin
				range_hi_reg <= pwdata[15:0];
			end
			if (wr_en && paddr == `LMT_OFS_PASSWORD) begin
				if (!locked_reg && pwdata[15:0] != 16'h0000) begin
					password_reg <= pwdata[15:0];
					locked_reg   <= 1'b1;
				end else if (locked_reg && pwdata[15:0] == password_reg) begin
					password_reg <= 16'h0000;
					locked_reg   <= 1'b0;
				end
			end
			if (wr_en && paddr == `LMT_OFS_EVSEL) begin
				evsel_reg <= pwdata[4:0];
			end
			if (wr_en && paddr == `LMT_OFS_IRQ_MASK) begin
				irq_mask_reg <= pwdata[3:0];
			end
		end
	end

	// ************************
	// Pin synchronisers
	// ************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= `LMT_SYNC_RST;
			sync2_reg <= `LMT_SYNC_RST;
		end else begin
			sync1_reg <= {restart_power_on_mode, alarm_in,
			              ack_contact, ack_key_n};
			sync2_reg <= sync1_reg;
		end
	end

	// ************************
	// Limit test and acknowledge
	// ************************
	assign high_mode = ctrl_reg[`LMT_CTRL_HIGH];
	assign violate = high_mode ?
		($signed(measured_value) > $signed(limit_setpoint_reg)) :
		($signed(measured_value) < $signed(limit_setpoint_reg));

	assign ack_lvl   = ctrl_reg[`LMT_CTRL_ACKSRC] ? sync2_reg[1] :
	                   ~sync2_reg[0];
	assign ack_pulse = ack_lvl & ~ack_prev_reg;
	assign ack_ok    = ack_pulse & trip_reg & ~violate & started_reg;
	assign ack_bad   = ack_pulse & trip_reg & violate & started_reg;

	always @* begin
		trip_next = trip_reg;
		if (!started_reg) begin
			if (start_cnt_reg == `LMT_START_EVAL) begin
				trip_next = ~sync2_reg[5] | violate;
			end
		end else if (violate) begin
			trip_next = 1'b1;
		end else if (ack_pulse) begin
			trip_next = 1'b0;
		end
	end

	// Latch starts set so the relay is safe until the strap is read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_reg        <= 1'b1;
			ack_prev_reg    <= 1'b0;
			start_cnt_reg   <= 2'h0;
			started_reg     <= 1'b0;
			exceeded_lamp   <= 1'b0;
			trip_lamp       <= 1'b1;
			relay_energized <= 1'b0;
			relay_nc_closed <= 1'b1;
			relay_no_closed <= 1'b0;
		end else begin
			ack_prev_reg <= ack_lvl;
			if (!started_reg) begin
				start_cnt_reg <= start_cnt_reg + 2'h1;
				if (start_cnt_reg == `LMT_START_EVAL) begin
					started_reg <= 1'b1;
				end
			end
			trip_reg        <= trip_next;
			exceeded_lamp   <= violate;
			trip_lamp       <= trip_next;
			relay_energized <= ~trip_next;
			relay_nc_closed <= trip_next;
			relay_no_closed <= ~trip_next;
		end
	end

	// ************************
	// Percent scaling
	// ************************
	// range low 0, high 100
	assign off_val  = {measured_value[15], measured_value} -
	                  {range_lo_reg[15], range_lo_reg};
	assign span_val = {range_hi_reg[15], range_hi_reg} -
	                  {range_lo_reg[15], range_lo_reg};
	assign below_lo = off_val[16] | (off_val == 17'h00000);
	assign above_hi = ($signed(off_val) >= $signed(span_val));
	assign in_range = ~below_lo & ~above_hi & ~span_val[16];
	assign div_num  = {8'h00, off_val[15:0]} * `LMT_PCT_FULL;

	lmt_div #(
		.NW (24),
		.DW (16)
	) i_lmt_div (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (in_range),
		.num     (div_num),
		.den     (span_val[15:0]),
		.busy    (div_busy),
		.done    (div_done),
		.quo     (div_quo)
	);

	// Result lags the input by one division; fine for a display value
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pct_reg      <= 7'h00;
			abnormal_reg <= 1'b0;
		end else begin
			abnormal_reg <= ~in_range & ~below_lo | off_val[16] |
			                span_val[16];
			if (span_val[16] || below_lo) begin
				pct_reg <= 7'h00;
			end else if (above_hi) begin
				pct_reg <= `LMT_PCT_MAX;
			end else if (div_done) begin
				pct_reg <= div_quo[6:0];
			end
		end
	end

	// ************************
	// Front panel lamps
	// ************************
	assign lvl       = ctrl_reg[`LMT_CTRL_LVL_HI:`LMT_CTRL_LVL_LO];
	assign alarm_any = |(sync2_reg[4:2] &
	                   evsel_reg[`LMT_EV_ALARM_HI:`LMT_EV_ALARM_LO]);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			easy_level_lamp   <= 1'b0;
			expert_level_lamp <= 1'b0;
			event_lamp        <= 1'b0;
			security_lamp     <= 1'b0;
			value_red         <= 1'b0;
			value_error_code  <= 1'b0;
		end else begin
			easy_level_lamp   <= (lvl == `LMT_LVL_EASY);
			expert_level_lamp <= (lvl == `LMT_LVL_EXPERT);
			event_lamp        <= alarm_any |
			                     (evsel_reg[`LMT_EV_TRIP] & trip_reg) |
			                     (evsel_reg[`LMT_EV_EXCEED] & violate);
			security_lamp     <= locked_reg;
			value_red         <= abnormal_reg | violate | measured_error;
			value_error_code  <= measured_error;
		end
	end

	// ************************
	// Interrupts
	// ************************
	assign irq_ev  = {ack_bad, ack_ok, violate & ~exceeded_lamp,
	                  trip_next & ~trip_reg};
	assign irq_clr = (wr_en && paddr == `LMT_OFS_IRQ_STS) ?
	                 pwdata[3:0] : 4'h0;

	// A new event wins over a clear in the same cycle
	always @* begin
		irq_sts_next = (irq_sts_reg & ~irq_clr) | irq_ev;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_sts_reg <= 4'h0;
			irq         <= 1'b0;
		end else begin
			irq_sts_reg <= irq_sts_next;
			irq         <= |(irq_sts_next & irq_mask_reg);
		end
	end

endmodule

//--- rtl/lmt_consts.vh
// Constants for the limit trip latch block
`ifndef LMT_CONSTS_VH
`define LMT_CONSTS_VH

// ************************
// Register byte offsets
// ************************
`define LMT_OFS_CTRL     8'h00
`define LMT_OFS_SETPOINT 8'h04
`define LMT_OFS_RANGE_LO 8'h08
`define LMT_OFS_RANGE_HI 8'h0C
`define LMT_OFS_PASSWORD 8'h10
`define LMT_OFS_STATUS   8'h14
`define LMT_OFS_PERCENT  8'h18
`define LMT_OFS_EVSEL    8'h1C
`define LMT_OFS_IRQ_STS  8'h20
`define LMT_OFS_IRQ_MASK 8'h24

// ************************
// Control fields
// ************************
`define LMT_CTRL_HIGH    0
`define LMT_CTRL_ACKSRC  1
`define LMT_CTRL_LVL_LO  2
`define LMT_CTRL_LVL_HI  3
`define LMT_LVL_EASY     2'h0
`define LMT_LVL_STD      2'h1
`define LMT_LVL_EXPERT   2'h2

// ************************
// Status fields
// ************************
`define LMT_ST_EXCEED    0
`define LMT_ST_TRIP      1
`define LMT_ST_RELAY     2
`define LMT_ST_LOCKED    3
`define LMT_ST_ABNORMAL  4
`define LMT_ST_ERROR     5
`define LMT_ST_STARTED   6

// ************************
// Event selection fields
// ************************
`define LMT_EV_ALARM_LO  0
`define LMT_EV_ALARM_HI  2
`define LMT_EV_TRIP      3
`define LMT_EV_EXCEED    4

// ************************
// Interrupt bits
// ************************
`define LMT_IRQ_TRIP     0
`define LMT_IRQ_EXCEED   1
`define LMT_IRQ_ACK_OK   2
`define LMT_IRQ_ACK_BAD  3
`define LMT_IRQ_W        4

// ************************
// Reset values, scaling and start-up constants
// ************************
`define LMT_CTRL_RST     4'h1
`define LMT_SETPT_RST    16'h0000
`define LMT_LO_RST       16'h0000
`define LMT_HI_RST       16'h03E8
`define LMT_EVSEL_RST    5'h07
`define LMT_SYNC_RST     6'h01
`define LMT_PCT_FULL     24'h000064
`define LMT_PCT_MAX      7'h64
`define LMT_START_EVAL   2'h2

`endif

//--- rtl/lmt_div.v
// Iterative unsigned divider used for percent scaling
`timescale 1ns/100ps
module lmt_div #(
	parameter NW = 24,
	parameter DW = 16
) (
	// Clock and reset
	input  wire          pclk,
	input  wire          presetn,
	// Request
	input  wire          start,
	input  wire [NW-1:0] num,
	input  wire [DW-1:0] den,
	// Result
	output wire          busy,
	output reg           done,
	output wire [NW-1:0] quo
);

	localparam [5:0] CNT_INIT = NW;

	reg  [NW-1:0] q_reg;
	reg  [DW-1:0] r_reg;
	reg  [5:0]    cnt_reg;
	reg           busy_reg;
	wire [DW:0]   shifted;
	wire          fits;

	assign shifted = {r_reg, q_reg[NW-1]};
	assign fits    = (shifted >= {1'b0, den});
	assign busy    = busy_reg;
	assign quo     = q_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_reg    <= {NW{1'b0}};
			r_reg    <= {DW{1'b0}};
			cnt_reg  <= 6'h00;
			busy_reg <= 1'b0;
			done     <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy_reg) begin
				if (start) begin
					q_reg    <= num;
					r_reg    <= {DW{1'b0}};
					cnt_reg  <= CNT_INIT;
					busy_reg <= 1'b1;
				end
			end else begin
				// One quotient bit per cycle keeps the area small
				if (fits) begin
					r_reg <= shifted[DW-1:0] - den;
					q_reg <= {q_reg[NW-2:0], 1'b1};
				end else begin
					r_reg <= shifted[DW-1:0];
					q_reg <= {q_reg[NW-2:0], 1'b0};
				end
				cnt_reg <= cnt_reg - 6'h01;
				if (cnt_reg == 6'h01) begin
					busy_reg <= 1'b0;
					done     <= 1'b1;
				end
			end
		end
	end

endmodule

//--- tb/lmt_trip_checker.sv
// Port-level assertions for the limit trip latch
`timescale 1ns/100ps
module lmt_trip_checker (
	// Clock and bus
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	// Field pins
	input wire ack_key_n,
	input wire ack_contact,
	input wire restart_power_on_mode,
	// Lamps and relay
	input wire exceeded_lamp,
	input wire trip_lamp,
	input wire easy_level_lamp,
	input wire expert_level_lamp,
	input wire relay_energized,
	input wire relay_nc_closed,
	input wire relay_no_closed
);
	// ************
	// Helpers
	// ************
	// Window of six edges covers the sync delay with margin
	reg  [2:0] cnt_reg;
	reg  [5:0] hist_reg;
	reg        key_q_reg;
	reg        con_q_reg;
	wire       ack_seen;
	assign ack_seen = (key_q_reg & ~ack_key_n) | (~con_q_reg & ack_contact);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 3'h0;
			hist_reg <= 6'h00;
			key_q_reg <= 1'b1;
			con_q_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + {2'h0, cnt_reg != 3'h7};
			hist_reg <= {hist_reg[4:0], ack_seen};
			key_q_reg <= ack_key_n;
			con_q_reg <= ack_contact;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ************
	// Properties
	// ************
	property p_relay;
		relay_nc_closed == trip_lamp && relay_no_closed != trip_lamp
			&& relay_energized != trip_lamp;
	endproperty
	a_relay: assert property (p_relay) else $error("relay state wrong");
	property p_exc;
		exceeded_lamp |-> trip_lamp;
	endproperty
	a_exc: assert property (p_exc) else $error("exceed without trip");
	property p_rise;
		$rose(trip_lamp) |-> exceeded_lamp;
	endproperty
	a_rise: assert property (p_rise) else $error("trip set idle");
	property p_clear;
		$fell(trip_lamp) && cnt_reg == 3'h7
			|-> (|hist_reg) && !$past(exceeded_lamp);
	endproperty
	a_clear: assert property (p_clear) else $error("trip cleared");
	property p_lvl;
		!(easy_level_lamp && expert_level_lamp);
	endproperty
	a_lvl: assert property (p_lvl) else $error("two level lamps");
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_start0;
		!restart_power_on_mode && cnt_reg >= 3'h1 && cnt_reg <= 3'h4
			|-> trip_lamp;
	endproperty
	a_start0: assert property (p_start0) else $error("start trip");
	property p_start1;
		restart_power_on_mode && cnt_reg == 3'h4 && !exceeded_lamp
			|-> !trip_lamp;
	endproperty
	a_start1: assert property (p_start1) else $error("start run");
	cover property ($fell(trip_lamp));
	cover property ($rose(exceeded_lamp));
	cover property (expert_level_lamp);
endmodule

bind lmt_trip lmt_trip_checker i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .ack_key_n(ack_key_n), .ack_contact(ack_contact),
	.restart_power_on_mode(restart_power_on_mode),
	.exceeded_lamp(exceeded_lamp), .trip_lamp(trip_lamp),
	.easy_level_lamp(easy_level_lamp),
	.expert_level_lamp(expert_level_lamp),
	.relay_energized(relay_energized), .relay_nc_closed(relay_nc_closed),
	.relay_no_closed(relay_no_closed)
);

//--- tb/lmt_field.sv
// Model of the measurement source, operator pins and strap
`timescale 1ns/100ps
module lmt_field (
	// Clock
	input  wire        pclk,
	// Field side
	output reg  [15:0] measured_value,
	output reg         measured_error,
	output reg         ack_key_n,
	output reg         ack_contact,
	output reg  [2:0]  alarm_in,
	output reg         restart_power_on_mode
);
	initial begin
		measured_value = 16'h0000;
		measured_error = 1'b0;
		ack_key_n = 1'b1;
		ack_contact = 1'b0;
		alarm_in = 3'h0;
		restart_power_on_mode = 1'b0;
	end
	// Held four edges so the two-stage sync cannot miss it
	task press(input logic contact);
		if (contact)
			ack_contact <= 1'b1;
		else
			ack_key_n <= 1'b0;
		repeat (4) @(posedge pclk);
		ack_contact <= 1'b0;
		ack_key_n <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask
endmodule

//--- tb/tb_limit_trip_latch.sv
// Self-checking bench for the limit trip latch
`timescale 1ns/100ps
module tb_limit_trip_latch;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	logic        err;
	wire  [31:0] prdata;
	wire  [15:0] measured_value;
	wire  [2:0]  alarm_in;
	wire         pready, pslverr, measured_error, ack_key_n, ack_contact;
	wire         restart_power_on_mode, exceeded_lamp, trip_lamp, irq;
	wire         easy_level_lamp, expert_level_lamp, event_lamp;
	wire         security_lamp, value_red, value_error_code;
	wire         relay_energized, relay_nc_closed, relay_no_closed;
	wire  [2:0]  relay_st;
	assign relay_st = {relay_energized, relay_nc_closed, relay_no_closed};
	int          miscompares = 0;
	int          tests_run = 0;
	lmt_trip i_lmt_trip (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.measured_value(measured_value), .measured_error(measured_error),
		.ack_key_n(ack_key_n), .ack_contact(ack_contact),
		.alarm_in(alarm_in), .restart_power_on_mode(restart_power_on_mode),
		.exceeded_lamp(exceeded_lamp), .trip_lamp(trip_lamp),
		.easy_level_lamp(easy_level_lamp), .event_lamp(event_lamp),
		.expert_level_lamp(expert_level_lamp), .value_red(value_red),
		.security_lamp(security_lamp),
		.value_error_code(value_error_code),
		.relay_energized(relay_energized), .relay_nc_closed(relay_nc_closed),
		.relay_no_closed(relay_no_closed), .irq(irq));
	lmt_field i_lmt_field (.pclk(pclk), .measured_value(measured_value),
		.measured_error(measured_error), .ack_key_n(ack_key_n),
		.ack_contact(ack_contact), .alarm_in(alarm_in),
		.restart_power_on_mode(restart_power_on_mode));
	always #5 pclk = ~pclk;
	// ************
	// Helpers
	// ************
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task set_value(input logic [15:0] v);
		i_lmt_field.measured_value <= v;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ************
	// Scenarios
	// ************
	task t_power0;
		cyc(4);
		chk(trip_lamp, 1'b1);
		chk(relay_st, 3'h2);
		chk(easy_level_lamp, 1'b1);
		apb(0, 8'h00, 0);
		chk(rd, 32'h1);
		apb(0, 8'h0C, 0);
		chk(rd, 32'h3E8);
		$display("power0 done");
	endtask
	task t_trip_ack;
		apb(1, 8'h04, 32'h64);
		set_value(16'h32);
		i_lmt_field.press(0);
		chk(trip_lamp, 1'b0);
		chk(relay_st, 3'h5);
		set_value(16'h96);
		cyc(3);
		chk(exceeded_lamp, 1'b1);
		chk(relay_st, 3'h2);
		i_lmt_field.press(0);
		chk(trip_lamp, 1'b1);
		set_value(16'h32);
		cyc(3);
		chk({exceeded_lamp, trip_lamp}, 2'h1);
		i_lmt_field.press(0);
		chk(trip_lamp, 1'b0);
		$display("trip_ack done");
	endtask
	task t_low_contact;
		apb(1, 8'h00, 32'h6);
		cyc(3);
		chk(trip_lamp, 1'b1);
		chk({easy_level_lamp, expert_level_lamp}, 2'h0);
		set_value(16'h96);
		cyc(3);
		chk(exceeded_lamp, 1'b0);
		i_lmt_field.press(0);
		chk(trip_lamp, 1'b1);
		i_lmt_field.press(1);
		chk(trip_lamp, 1'b0);
		// Below setpoint in low mode: latch sets again and stays set
		set_value(16'h32);
		cyc(3);
		chk(trip_lamp, 1'b1);
		apb(1, 8'h00, 32'h9);
		cyc(2);
		chk({easy_level_lamp, expert_level_lamp}, 2'h1);
		$display("low_contact done");
	endtask
	task t_regs_irq;
		chk(irq, 1'b0);
		apb(0, 8'h20, 0);
		chk(rd, 32'hF);
		apb(1, 8'h24, 32'hF);
		cyc(2);
		chk(irq, 1'b1);
		apb(1, 8'h20, 32'hF);
		cyc(2);
		chk(irq, 1'b0);
		apb(1, 8'h14, 32'hFF);
		apb(0, 8'h14, 0);
		chk(rd, 32'h42);
		apb(0, 8'h40, 0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		$display("regs_irq done");
	endtask
	task t_misc;
		i_lmt_field.alarm_in <= 3'h4;
		cyc(5);
		chk(event_lamp, 1'b1);
		apb(1, 8'h10, 32'h5A);
		cyc(2);
		chk(security_lamp, 1'b1);
		apb(1, 8'h00, 32'h0);
		apb(0, 8'h00, 0);
		chk(rd, 32'h9);
		apb(1, 8'h10, 32'h5A);
		cyc(2);
		chk(security_lamp, 1'b0);
		i_lmt_field.measured_error <= 1'b1;
		cyc(4);
		chk({value_error_code, value_red}, 2'h3);
		i_lmt_field.measured_error <= 1'b0;
		apb(1, 8'h04, 32'h7FFF);
		set_value(16'h7D0);
		cyc(4);
		chk({value_error_code, value_red}, 2'h1);
		set_value(16'h1F4);
		cyc(40);
		apb(0, 8'h18, 0);
		chk(rd, 32'h32);
		$display("misc done");
	endtask
	// Restart strap at 1: runs unless the value violates at once
	task t_power1;
		for (int i = 0; i < 2; i++) begin
			presetn <= 1'b0;
			i_lmt_field.restart_power_on_mode <= 1'b1;
			set_value(i ? 16'h10 : 16'h0);
			cyc(6);
			presetn <= 1'b1;
			cyc(6);
			chk(trip_lamp, i[0]);
		end
		$display("power1 done");
	endtask
	initial begin
		cyc(6);
		presetn <= 1'b1;
		t_power0;
		t_trip_ack;
		t_low_contact;
		t_regs_irq;
		t_misc;
		t_power1;
		end_of_test;
	end
	initial begin
		cyc(5000);
		miscompares++;
		end_of_test;
	end
endmodule
